// [logic/pmbus_target_defines.vh]
// constants for the management-port target: addresses, commands, strap coding, timing
// assumes the including file uses the macros only as sized constants
`ifndef PMBUS_TARGET_DEFINES_VH
`define PMBUS_TARGET_DEFINES_VH

// ----------------------------------------------------------------
// bus addresses and commands
// ----------------------------------------------------------------
`define ALERT_RESP_ADDR   7'h0C
`define CMD_CLEAR_FAULTS  8'h03
`define CMD_SET_ADDRESS   8'hD3
`define ADDR_STRAP_OPEN   7'h3F
`define ADDR_HI_LOW_ISET  3'h3
`define ADDR_HI_HIGH_ISET 3'h4
`define STRAP_BIN_LAST    4'h7

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_KHZ           20000
`define BUS_MAX_KHZ       1000
// core cycles per half bus period at the fastest bus clock
`define HALF_BIT_CYCLES   (`CLK_KHZ / (2 * `BUS_MAX_KHZ))
`define STRAP_SETTLE      2'h3
`define FAULT_W           8

`endif

// [logic/sync2.v]
// two-flop synchroniser for a group of independent level inputs
// assumes each bit is a slow level or a clock far below clk_in
`timescale 1ns/1ns
module sync2 #(
   parameter W = 1
) (
   input  wire         clk_in,
   input  wire         arst_n_in,
   input  wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);
   reg [W-1:0] meta_reg;
   reg [W-1:0] sync_reg;

   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         meta_reg <= {W{1'b1}};
         sync_reg <= {W{1'b1}};
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;
endmodule // sync2

// [logic/pmbus_target.v]
// management-port target: own address selection, alert line and alert-response answer
// assumes scl/sda/strap inputs are asynchronous; fault and store inputs are on clk_in
//
// Contract
// - the port works with a bus clock up to 1 MHz and the host never clocks it faster.
// - a write of the set-address command changes the own address, used from then on.
// - after reset the address comes from the store if valid, else from the straps, low nibble bin 0..7, high 3 or 4, open 3Fh.
// - a read to address 0x0C while the alert is asserted is answered as an alert query.
// - the alert stays asserted until a clearing event, not when the condition goes away.
// - the alert is released after the own address was sent fully in answer to 0x0C.
// - the alert is released when the clear-faults command arrives.
// - configuration is kept in a reprogrammable nonvolatile store.
// - clear-faults clears all status bits at once and never restarts a latched-off output.
// - a fault still present when cleared sets its bit again at once and raises the alert again.
`timescale 1ns/1ns
`include "pmbus_target_defines.vh"
module pmbus_target (
   input  wire                 clk_in,
   input  wire                 arst_n_in,
   input  wire                 scl_in,
   input  wire                 sda_in,
   output wire                 sda_out,
   output wire                 sda_oe_n_out,
   output wire                 alert_oe_n_out,
   output wire                 alert_active_out,
   input  wire [3:0]           addr_strap_bin_in,
   input  wire                 current_set_strap_resistor_in,
   input  wire                 store_valid_in,
   input  wire [6:0]           store_addr_in,
   output wire                 store_write_out,
   output wire [6:0]           store_data_out,
   input  wire [`FAULT_W-1:0]  fault_in,
   output wire [`FAULT_W-1:0]  status_out,
   output wire                 clear_faults_out,
   output wire [6:0]           own_addr_out
);
   // ----------------------------------------------------------------
   // states
   // ----------------------------------------------------------------
   localparam ST_IDLE  = 3'h0;
   localparam ST_ADDR  = 3'h1;
   localparam ST_ACK   = 3'h2;
   localparam ST_RX    = 3'h3;
   localparam ST_TX    = 3'h4;
   localparam ST_WAIT  = 3'h5;

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   wire [6:0] sync_w;
   // half a bus period is many core cycles at 1 MHz, so the sync delay stays well inside it
   sync2 #(.W(7)) u_sync (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .async_in  ({scl_in, sda_in, current_set_strap_resistor_in, addr_strap_bin_in}),
      .sync_out  (sync_w)
   );
   wire       scl_s  = sync_w[6];
   wire       sda_s  = sync_w[5];
   wire       iset_s = sync_w[4];
   wire [3:0] bin_s  = sync_w[3:0];

   reg scl_d_reg;
   reg sda_d_reg;
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end
   wire scl_rise = scl_s & ~scl_d_reg;
   wire scl_fall = ~scl_s & scl_d_reg;
   wire start_c  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   wire stop_c   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   // ----------------------------------------------------------------
   // own address
   // ----------------------------------------------------------------
   reg  [6:0] own_addr_reg;
   reg  [1:0] settle_reg;
   reg        addr_loaded_reg;
   reg        addr_wr_pulse;
   reg  [6:0] addr_wr_data;
   wire [6:0] strap_addr = (bin_s > `STRAP_BIN_LAST) ? `ADDR_STRAP_OPEN :
                           {(iset_s ? `ADDR_HI_HIGH_ISET : `ADDR_HI_LOW_ISET), bin_s};

   // straps are read a few cycles after release so the synchronisers hold real pin levels
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         own_addr_reg    <= `ADDR_STRAP_OPEN;
         settle_reg      <= 2'h0;
         addr_loaded_reg <= 1'b0;
      end else if (!addr_loaded_reg) begin
         if (settle_reg == `STRAP_SETTLE) begin
            addr_loaded_reg <= 1'b1;
            // a programmed address in the store overrides the straps
            own_addr_reg    <= store_valid_in ? store_addr_in : strap_addr;
         end else begin
            settle_reg <= settle_reg + 2'h1;
         end
      end else if (addr_wr_pulse) begin
         own_addr_reg <= addr_wr_data;
      end
   end

   // ----------------------------------------------------------------
   // status and alert
   // ----------------------------------------------------------------
   reg  [`FAULT_W-1:0] status_reg;
   reg                 alert_reg;
   reg                 clr_pulse;
   reg                 ara_done_pulse;
   // a fault present during the clear re-sets its bit in the same edge
   wire [`FAULT_W-1:0] status_next = clr_pulse ? fault_in : (status_reg | fault_in);
   wire                new_fault   = |(fault_in & (clr_pulse ? {`FAULT_W{1'b1}} : ~status_reg));

   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         status_reg <= {`FAULT_W{1'b0}};
         alert_reg  <= 1'b0;
      end else begin
         status_reg <= status_next;
         if (new_fault)
            alert_reg <= 1'b1;
         else if (clr_pulse | ara_done_pulse)
            alert_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // bus target state machine
   // ----------------------------------------------------------------
   reg [2:0] state_reg;
   reg [2:0] after_ack_reg;
   reg [3:0] bit_cnt_reg;
   reg [7:0] shift_reg;
   reg [7:0] tx_reg;
   reg       data_is_addr_reg;
   reg       drive_low_reg;

   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_reg        <= ST_IDLE;
         after_ack_reg    <= ST_IDLE;
         bit_cnt_reg      <= 4'h0;
         shift_reg        <= 8'h00;
         tx_reg           <= 8'h00;
         data_is_addr_reg <= 1'b0;
         drive_low_reg    <= 1'b0;
         clr_pulse        <= 1'b0;
         ara_done_pulse   <= 1'b0;
         addr_wr_pulse    <= 1'b0;
         addr_wr_data     <= 7'h00;
      end else begin
         clr_pulse      <= 1'b0;
         ara_done_pulse <= 1'b0;
         addr_wr_pulse  <= 1'b0;
         if (start_c) begin
            state_reg     <= addr_loaded_reg ? ST_ADDR : ST_WAIT;
            bit_cnt_reg   <= 4'h0;
            drive_low_reg <= 1'b0;
         end else if (stop_c) begin
            state_reg     <= ST_IDLE;
            drive_low_reg <= 1'b0;
         end else begin
            case (state_reg)
               ST_ADDR, ST_RX: begin
                  if (scl_rise) begin
                     shift_reg   <= {shift_reg[6:0], sda_s};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                     bit_cnt_reg <= 4'h0;
                     if (state_reg == ST_ADDR) begin
                        if (shift_reg[7:1] == own_addr_reg && !shift_reg[0]) begin
                           drive_low_reg    <= 1'b1;
                           data_is_addr_reg <= 1'b0;
                           state_reg        <= ST_ACK;
                           after_ack_reg    <= ST_RX;
                        end else if (shift_reg[7:1] == `ALERT_RESP_ADDR && shift_reg[0]
                                     && alert_reg) begin
                           drive_low_reg <= 1'b1;
                           tx_reg        <= {own_addr_reg, 1'b0};
                           state_reg     <= ST_ACK;
                           after_ack_reg <= ST_TX;
                        end else begin
                           state_reg <= ST_WAIT;
                        end
                     end else if (data_is_addr_reg) begin
                        addr_wr_pulse <= 1'b1;
                        addr_wr_data  <= shift_reg[6:0];
                        drive_low_reg <= 1'b1;
                        state_reg     <= ST_ACK;
                        after_ack_reg <= ST_WAIT;
                     end else begin
                        // clear-faults carries no data, so it acts on the command byte
                        clr_pulse        <= (shift_reg == `CMD_CLEAR_FAULTS);
                        data_is_addr_reg <= (shift_reg == `CMD_SET_ADDRESS);
                        drive_low_reg    <= 1'b1;
                        state_reg        <= ST_ACK;
                        after_ack_reg    <= ST_RX;
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     state_reg     <= after_ack_reg;
                     drive_low_reg <= (after_ack_reg == ST_TX) ? ~tx_reg[7] : 1'b0;
                  end
               end
               ST_TX: begin
                  if (scl_rise) begin
                     if (tx_reg[7] && !sda_s) begin
                        // another target won the address phase; our alert stays up
                        drive_low_reg <= 1'b0;
                        state_reg     <= ST_WAIT;
                     end else begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                     end
                  end else if (scl_fall) begin
                     if (bit_cnt_reg == 4'h8) begin
                        drive_low_reg  <= 1'b0;
                        ara_done_pulse <= 1'b1;
                        state_reg      <= ST_WAIT;
                     end else begin
                        tx_reg        <= {tx_reg[6:0], 1'b1};
                        drive_low_reg <= ~tx_reg[6];
                     end
                  end
               end
               ST_IDLE, ST_WAIT: begin
                  drive_low_reg <= 1'b0;
               end
               default: begin
                  state_reg     <= ST_IDLE;
                  drive_low_reg <= 1'b0;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // open drain: only ever pull low, the pull-up makes the high level
   assign sda_out          = 1'b0;
   assign sda_oe_n_out     = ~drive_low_reg;
   assign alert_oe_n_out   = ~alert_reg;
   assign alert_active_out = alert_reg;
   assign store_write_out  = addr_wr_pulse;
   assign store_data_out   = addr_wr_data;
   assign status_out       = status_reg;
   // the power stage is told only to clear flags; a latched-off output is not restarted
   assign clear_faults_out = clr_pulse;
   assign own_addr_out     = own_addr_reg;
endmodule // pmbus_target

// [testbench/pmbus_target_props.sv]
// concurrent checks on the management-port target's top-level ports
// assumes one clk_in domain; bound to the design from the bench
`timescale 1ns/1ns
`include "pmbus_target_defines.vh"
module pmbus_target_props (
   input wire                clk_in,
   input wire                arst_n_in,
   input wire                scl_in,
   input wire                sda_in,
   input wire                sda_out,
   input wire                sda_oe_n_out,
   input wire                alert_oe_n_out,
   input wire                alert_active_out,
   input wire [3:0]          addr_strap_bin_in,
   input wire                current_set_strap_resistor_in,
   input wire                store_valid_in,
   input wire [6:0]          store_addr_in,
   input wire                store_write_out,
   input wire [6:0]          store_data_out,
   input wire [`FAULT_W-1:0] fault_in,
   input wire [`FAULT_W-1:0] status_out,
   input wire                clear_faults_out,
   input wire [6:0]          own_addr_out
);
   // ------------
   // properties
   // ------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   // a clear with no fault pending must leave nothing behind
   sequence s_clear_quiet; clear_faults_out && fault_in == 8'h00; endsequence
   sequence s_new_fault; |(fault_in & ~status_out); endsequence
   property p_status_take;
      |fault_in |=> (status_out & $past(fault_in)) == $past(fault_in);
   endproperty
   property p_alert_set; s_new_fault |-> ##[1:2] alert_active_out; endproperty
   // the ARA release lands while the host holds the clock low
   property p_alert_hold;
      $fell(alert_active_out) |-> $past(clear_faults_out) || $past(clear_faults_out, 2) || !scl_in;
   endproperty
   property p_clear_drop; s_clear_quiet |-> ##[1:2] !alert_active_out; endproperty
   property p_clear_status; s_clear_quiet |-> ##[0:2] status_out == 8'h00; endproperty
   property p_pulse_once; clear_faults_out |=> !clear_faults_out; endproperty
   property p_store_apply; store_write_out |-> ##[1:2] own_addr_out == store_data_out; endproperty
   // a pulled alert pin must always be backed by a latched status bit
   property p_alert_pin;
      alert_oe_n_out != alert_active_out && (alert_oe_n_out || status_out != 8'h00);
   endproperty
   property p_sda_in_low; $changed(sda_oe_n_out) |-> !scl_in; endproperty
   a_status_take: assert property (p_status_take) else $error("fault not latched");
   a_alert_set: assert property (p_alert_set) else $error("alert not raised");
   a_alert_hold: assert property (p_alert_hold) else $error("alert dropped alone");
   a_clear_drop: assert property (p_clear_drop) else $error("alert kept on clear");
   a_clear_status: assert property (p_clear_status) else $error("status kept");
   a_pulse_once: assert property (p_pulse_once) else $error("clear pulse long");
   a_store_apply: assert property (p_store_apply) else $error("address not applied");
   a_alert_pin: assert property (p_alert_pin) else $error("alert pin mismatch");
   a_sda_in_low: assert property (p_sda_in_low) else $error("sda moved, scl high");
endmodule // pmbus_target_props

// [testbench/host_model.sv]
// bus host model: makes scl at 1 MHz and drives its side of sda
// assumes sda_in is the resolved line with a pull-up
`timescale 1ns/1ns
module host_model (
   output logic scl_out,
   output logic sda_drv_out,
   input  wire  sda_in
);
   // clock stands high between frames
   initial begin
      scl_out = 1'b1;
      sda_drv_out = 1'b1;
   end
   task start;
      sda_drv_out = 1'b0;
      #500;
      scl_out = 1'b0;
      #100;
   endtask
   // 600 ns low, 400 ns high: never above 1 MHz; data sampled just before the fall
   task automatic xfer(input [7:0] tx, output logic [7:0] rx, output logic nack);
      for (int i = 8; i >= 0; i--) begin
         sda_drv_out = (i == 0) ? 1'b1 : tx[i-1];
         #500;
         scl_out = 1'b1;
         #400;
         if (i == 0) nack = sda_in;
         else rx[i-1] = sda_in;
         scl_out = 1'b0;
         #100;
      end
   endtask
   task stop;
      sda_drv_out = 1'b0;
      #500;
      scl_out = 1'b1;
      #500;
      sda_drv_out = 1'b1;
      #1000;
   endtask
endmodule // host_model

// [testbench/pmbus_target_tb.sv]
// self-checking bench for the management-port target
// assumes host_model drives the bus; the checker is bound at the foot
`timescale 1ns/1ns
`include "pmbus_target_defines.vh"
`define CHECK(nm, ex, ac) begin cmp_count++; if ((ac) !== (ex)) begin errors++; \
   $display("mismatch %s expected %h seen %h", nm, ex, ac); end end
module pmbus_target_tb;
   logic       clk_in = 1'b0;
   logic       arst_n_in = 1'b0;
   logic       iset = 1'b0;
   logic       store_valid = 1'b0;
   logic [3:0] strap_bin = 4'h0;
   logic [7:0] fault = 8'h00;
   wire        scl, host_sda, sda_out, sda_oe_n_out, alert_oe_n_out, alert_active_out;
   wire        store_write_out, clear_faults_out;
   wire  [6:0] store_data_out, own_addr_out;
   wire  [7:0] status_out;
   wire        sda_bus = host_sda & (sda_oe_n_out | sda_out);
   int         errors = 0;
   int         cmp_count = 0;
   pmbus_target u_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .scl_in(scl), .sda_in(sda_bus),
      .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .alert_oe_n_out(alert_oe_n_out),
      .alert_active_out(alert_active_out), .addr_strap_bin_in(strap_bin),
      .current_set_strap_resistor_in(iset), .store_valid_in(store_valid),
      .store_addr_in(7'h55), .store_write_out(store_write_out), .store_data_out(store_data_out),
      .fault_in(fault), .status_out(status_out), .clear_faults_out(clear_faults_out),
      .own_addr_out(own_addr_out));
   host_model u_host (.scl_out(scl), .sda_drv_out(host_sda), .sda_in(sda_bus));
   initial begin
      forever #25 clk_in = ~clk_in;
   end
   task tick(input int n);
      repeat (n) @(posedge clk_in);
      #5;
   endtask
   task summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ------------
   // scenarios
   // ------------
   task chk_strap(input [3:0] bin, input cs, input sv, input [6:0] exp);
      arst_n_in = 1'b0;
      strap_bin = bin;
      iset = cs;
      store_valid = sv;
      tick(4);
      arst_n_in = 1'b1;
      tick(12);
      `CHECK("own address", exp, own_addr_out)
   endtask
   task ara(input [7:0] drive, input [7:0] exp, input ack_exp);
      logic [7:0] rx;
      logic       nk;
      u_host.start();
      u_host.xfer({`ALERT_RESP_ADDR, 1'b1}, rx, nk);
      `CHECK("alert query ack", ack_exp, nk)
      if (nk == 1'b0) begin
         u_host.xfer(drive, rx, nk);
         `CHECK("alert answer", exp, rx)
      end
      u_host.stop();
      tick(1);
   endtask
   task wr(input [7:0] adr, input [7:0] cmd, input [7:0] dat, input dat_en, input ack_exp);
      logic [7:0] rx;
      logic       nk;
      u_host.start();
      u_host.xfer(adr, rx, nk);
      `CHECK("write address ack", ack_exp, nk)
      if (nk == 1'b0) u_host.xfer(cmd, rx, nk);
      if (nk == 1'b0 && dat_en) u_host.xfer(dat, rx, nk);
      u_host.stop();
      tick(1);
   endtask
   task raise(input [7:0] f);
      fault = f;
      tick(1);
      fault = 8'h00;
      tick(20);
   endtask
   task t_alert_query;
      `CHECK("alert idle", 1'b0, alert_active_out)
      ara(8'hFF, 8'h00, 1'b1);
      raise(8'h04);
      `CHECK("alert held", 1'b1, alert_active_out)
      `CHECK("status sticky", 8'h04, status_out)
      ara(8'hFF, 8'h60, 1'b0);
      `CHECK("alert released", 1'b1, alert_oe_n_out)
   endtask
   task t_clear;
      raise(8'h01);
      wr(8'h60, `CMD_CLEAR_FAULTS, 8'h00, 1'b0, 1'b0);
      `CHECK("alert after clear", 1'b0, alert_active_out)
      `CHECK("status after clear", 8'h00, status_out)
      fault = 8'h82;
      tick(4);
      wr(8'h60, `CMD_CLEAR_FAULTS, 8'h00, 1'b0, 1'b0);
      `CHECK("status refilled", 8'h82, status_out)
      `CHECK("alert again", 1'b1, alert_active_out)
      fault = 8'h00;
      wr(8'h60, `CMD_CLEAR_FAULTS, 8'h00, 1'b0, 1'b0);
      `CHECK("alert quiet", 1'b0, alert_active_out)
   endtask
   task t_set_addr;
      wr(8'h60, `CMD_SET_ADDRESS, 8'hD2, 1'b1, 1'b0);
      `CHECK("new address", 7'h52, own_addr_out)
      `CHECK("stored address", 7'h52, store_data_out)
      wr(8'h60, 8'h11, 8'h00, 1'b0, 1'b1);
      wr(8'hA4, 8'h11, 8'h00, 1'b0, 1'b0);
      // a read to the own address is not answered: no read commands here
      wr(8'hA5, 8'h11, 8'h00, 1'b0, 1'b1);
   endtask
   // a zero driven by the host stands for a rival answering with a lower address
   task t_arbitration;
      raise(8'h10);
      ara(8'h00, 8'h00, 1'b0);
      `CHECK("alert kept after loss", 1'b1, alert_active_out)
      ara(8'hFF, 8'hA4, 1'b0);
      `CHECK("alert released", 1'b0, alert_active_out)
   endtask
   initial begin
      chk_strap(4'h8, 1'b1, 1'b0, 7'h3F);
      chk_strap(4'h7, 1'b1, 1'b0, 7'h47);
      chk_strap(4'h3, 1'b0, 1'b1, 7'h55);
      chk_strap(4'h0, 1'b0, 1'b0, 7'h30);
      t_alert_query();
      t_clear();
      t_set_addr();
      t_arbitration();
      summarize();
   end
   initial begin
      repeat (100000) @(posedge clk_in);
      errors++;
      summarize();
   end
endmodule // pmbus_target_tb
bind pmbus_target pmbus_target_props u_props (.clk_in(clk_in), .arst_n_in(arst_n_in),
   .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
   .alert_oe_n_out(alert_oe_n_out), .alert_active_out(alert_active_out),
   .addr_strap_bin_in(addr_strap_bin_in), .store_valid_in(store_valid_in),
   .current_set_strap_resistor_in(current_set_strap_resistor_in),
   .store_addr_in(store_addr_in), .store_write_out(store_write_out),
   .store_data_out(store_data_out), .fault_in(fault_in), .status_out(status_out),
   .clear_faults_out(clear_faults_out), .own_addr_out(own_addr_out));
